// ===== core/burst_shaper.sv
// burst sequencer: four drive inputs from the internal clock ticks
`timescale 1ns/1ps
`default_nettype none
module burst_shaper #(
    parameter int LW = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic cw,
    input wire logic invert,
    input wire logic [LW-1:0] cycles,
    output logic busy,
    output logic drv_a,
    output logic drv_b,
    output logic drv_c,
    output logic drv_d
);
    logic half_q;
    logic [LW:0] cnt_q;
    logic [LW:0] last_half;

    assign last_half = {cycles, 1'b0} - {{LW{1'b0}}, 1'b1};

    // a start during a running burst is ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            half_q <= 1'b0;
            cnt_q <= '0;
        end else if (cw) begin
            busy <= 1'b1;
            cnt_q <= '0;
            if (tick) begin
                half_q <= !half_q;
            end
        end else if (!busy) begin
            if (start) begin
                busy <= 1'b1;
                half_q <= 1'b0;
                cnt_q <= '0;
            end
        end else if (tick) begin
            half_q <= !half_q;
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == last_half) begin
                busy <= 1'b0;
            end
        end
    end

    // idle holds the return-to-zero clamp on c and d
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drv_a <= 1'b0;
            drv_b <= 1'b0;
            drv_c <= 1'b1;
            drv_d <= 1'b1;
        end else begin
            drv_a <= busy && (half_q == invert);
            drv_b <= busy && (half_q != invert);
            drv_c <= !busy;
            drv_d <= !busy;
        end
    end
endmodule
`default_nettype wire

// ===== core/button_filter.sv
// debounce for active-low push buttons, one pulse per press
`timescale 1ns/1ps
`default_nettype none
module button_filter #(
    parameter int WIDTH = 5,
    parameter int HOLD = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] raw_n,
    output logic [WIDTH-1:0] press
);
    localparam int CW = $clog2(HOLD + 1);
    logic [CW-1:0] cnt_q [WIDTH];
    logic [WIDTH-1:0] level_q;

    // level must stay put for HOLD cycles before it counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < WIDTH; i++) begin
                cnt_q[i] <= '0;
            end
            level_q <= '0;
            press <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                press[i] <= 1'b0;
                if (!raw_n[i] != level_q[i]) begin
                    if (cnt_q[i] == CW'(HOLD - 1)) begin
                        cnt_q[i] <= '0;
                        level_q[i] <= !raw_n[i];
                        press[i] <= !raw_n[i];
                    end else begin
                        cnt_q[i] <= cnt_q[i] + 1'b1;
                    end
                end else begin
                    cnt_q[i] <= '0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== core/pulser_ctrl.sv
// pulser demo controller: buttons, rate, trigger, drive and register bus
`timescale 1ns/1ps
`default_nettype none
// Contract
// - drive toggle at half internal clock
// - internal trigger 5000 Hz, external faster (internal is 5000 Hz at top rate only, scales with rate)
// - rate button steps 20 MHz to 0.625
// - pattern button changes waveform pattern
// - monitor button picks scope copy
// - enable button sets output enable (variant high only; variant low ties the enable line high)
// - red lamp lit while enable high
// - green lamp shows supply good
// - phase button inverts drive sequence
// - external trigger starts each burst
// - variant sense adapts enable handling
// - burst duty near 25 percent slow
// - lamps show current selection
module pulser_ctrl #(
    parameter int DEBOUNCE_CYCLES = pulser_pkg::DEBOUNCE_CYC,
    parameter int TRIG_TICKS = pulser_pkg::TRIG_DIV
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // axi write address and data
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // axi write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi read
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // buttons, active low
    input wire logic PATTERN_BUTTON_N,
    input wire logic RATE_BUTTON_N,
    input wire logic MONITOR_BUTTON_N,
    input wire logic ENABLE_BUTTON_N,
    input wire logic PHASE_BUTTON_N,
    // trigger and variant strap
    input wire logic EXTERNAL_SYNC_IN,
    input wire logic VARIANT_SENSE,
    // driver inputs
    output logic DRIVE_A,
    output logic DRIVE_B,
    output logic DRIVE_C,
    output logic DRIVE_D,
    output logic DRIVE_OE,
    output logic SCOPE_MONITOR_OUT,
    // lamps
    output logic CHOICE_LAMP_1,
    output logic CHOICE_LAMP_2,
    output logic CHOICE_LAMP_3,
    output logic ARMED_LAMP,
    output logic SUPPLY_GOOD_LAMP
);
    localparam int TW = $clog2(TRIG_TICKS + 1);

    function automatic logic mapped(input logic [7:0] a);
        return a == pulser_pkg::MODE_OFF || a == pulser_pkg::BURST_OFF
            || a == pulser_pkg::STATUS_OFF;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////
    // buttons: 0 pattern, 1 rate, 2 monitor, 3 enable, 4 phase
    logic [4:0] press;
    button_filter #(.WIDTH(5), .HOLD(DEBOUNCE_CYCLES)) u_buttons (
        .clk(CLK),
        .rst(RST),
        .raw_n({PHASE_BUTTON_N, ENABLE_BUTTON_N, MONITOR_BUTTON_N,
            RATE_BUTTON_N, PATTERN_BUTTON_N}),
        .press(press)
    );

    ////////////////////////////////////////////////////////////////
    // axi-lite write channel
    logic awready_q, wready_q, bvalid_q;
    logic [1:0] bresp_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_wr, wr_mode, wr_burst, b_done;

    assign do_wr = !awready_q && !wready_q && !bvalid_q;
    assign wr_mode = do_wr && awaddr_q == pulser_pkg::MODE_OFF;
    assign wr_burst = do_wr && awaddr_q == pulser_pkg::BURST_OFF;
    assign b_done = bvalid_q && BREADY;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            awready_q <= 1'b1;
            awaddr_q <= 8'h00;
        end else if (AWVALID && awready_q) begin
            awready_q <= 1'b0;
            awaddr_q <= AWADDR;
        end else if (b_done) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wready_q <= 1'b1;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (WVALID && wready_q) begin
            wready_q <= 1'b0;
            wdata_q <= WDATA;
            wstrb_q <= WSTRB;
        end else if (b_done) begin
            wready_q <= 1'b1;
        end
    end

    // writes to the status word are accepted and dropped
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bvalid_q <= 1'b0;
            bresp_q <= pulser_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= mapped(awaddr_q) ? pulser_pkg::RESP_OKAY
                : pulser_pkg::RESP_SLVERR;
        end else if (b_done) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // selections; a bus write wins over a press in the same cycle
    pulser_pkg::pattern_type pat_q;
    logic [2:0] rate_q;
    logic [1:0] mon_q;
    logic armed_q, invert_q, ext_en_q;
    logic [15:0] burst_q;
    logic [31:0] mode_rd, mode_new, burst_new;

    assign mode_rd = {22'h000000, ext_en_q, invert_q, armed_q, mon_q, rate_q, pat_q};
    assign mode_new = merge(mode_rd, wdata_q, wstrb_q);
    assign burst_new = merge({16'h0000, burst_q}, wdata_q, wstrb_q);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pat_q <= pulser_pkg::PAT_PULSE;
        end else if (wr_mode) begin
            unique case (mode_new[pulser_pkg::MODE_PAT_LSB +: 2])
                2'h1: pat_q <= pulser_pkg::PAT_BURST;
                2'h2: pat_q <= pulser_pkg::PAT_CW;
                default: pat_q <= pulser_pkg::PAT_PULSE;
            endcase
        end else if (press[0]) begin
            unique case (pat_q)
                pulser_pkg::PAT_PULSE: pat_q <= pulser_pkg::PAT_BURST;
                pulser_pkg::PAT_BURST: pat_q <= pulser_pkg::PAT_CW;
                default: pat_q <= pulser_pkg::PAT_PULSE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rate_q <= pulser_pkg::RATE_RST;
        end else if (wr_mode) begin
            rate_q <= (mode_new[pulser_pkg::MODE_RATE_LSB +: 3] > pulser_pkg::RATE_LAST)
                ? 3'h0 : mode_new[pulser_pkg::MODE_RATE_LSB +: 3];
        end else if (press[1]) begin
            rate_q <= (rate_q == pulser_pkg::RATE_LAST) ? 3'h0 : 3'(rate_q + 3'h1);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mon_q <= pulser_pkg::MON_RST;
            armed_q <= 1'b0;
            invert_q <= 1'b0;
            ext_en_q <= 1'b0;
        end else if (wr_mode) begin
            mon_q <= mode_new[pulser_pkg::MODE_MON_LSB +: 2];
            armed_q <= mode_new[pulser_pkg::MODE_ARM_BIT];
            invert_q <= mode_new[pulser_pkg::MODE_INV_BIT];
            ext_en_q <= mode_new[pulser_pkg::MODE_EXT_BIT];
        end else begin
            mon_q <= mon_q + {1'b0, press[2]};
            armed_q <= armed_q ^ press[3];
            invert_q <= invert_q ^ press[4];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            burst_q <= pulser_pkg::BURST_RST;
        end else if (wr_burst) begin
            burst_q <= burst_new[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // internal clock: phase accumulator, halved per rate step
    logic [31:0] acc_q;
    logic tick_q;
    logic [32:0] acc_sum;

    assign acc_sum = {1'b0, acc_q} + {1'b0, pulser_pkg::NCO_INC >> rate_q};

    // one drive half-cycle per internal clock tick
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            acc_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            acc_q <= acc_sum[31:0];
            tick_q <= acc_sum[32];
        end
    end

    ////////////////////////////////////////////////////////////////
    // burst trigger
    logic [TW-1:0] trig_cnt_q;
    logic [15:0] trig_count_q;
    logic ext_prev_q, ext_fire, int_fire, trig_fire;

    // external edge starts a burst and restarts the count
    assign ext_fire = ext_en_q && EXTERNAL_SYNC_IN && !ext_prev_q;
    // internal repeat counts internal ticks, so it scales with rate
    assign int_fire = tick_q && trig_cnt_q == TW'(TRIG_TICKS - 1);
    assign trig_fire = ext_fire || int_fire;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ext_prev_q <= 1'b0;
            trig_cnt_q <= '0;
            trig_count_q <= 16'h0000;
        end else begin
            ext_prev_q <= EXTERNAL_SYNC_IN;
            if (trig_fire) begin
                trig_cnt_q <= '0;
                trig_count_q <= trig_count_q + 16'h0001;
            end else if (tick_q) begin
                trig_cnt_q <= trig_cnt_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // burst length per pattern
    logic [15:0] len_eff;
    logic busy;
    logic sh_a, sh_b, sh_c, sh_d;

    // slow bursts capped to a quarter of the trigger period
    always_comb begin
        unique case (pat_q)
            pulser_pkg::PAT_BURST: begin
                if (rate_q >= pulser_pkg::PW_LIMIT_RATE && burst_q > pulser_pkg::PW_MAX_CYC) begin
                    len_eff = pulser_pkg::PW_MAX_CYC;
                end else begin
                    len_eff = (burst_q == 16'h0000) ? 16'h0001 : burst_q;
                end
            end
            default: len_eff = 16'h0001;
        endcase
    end

    burst_shaper #(.LW(16)) u_shaper (
        .clk(CLK),
        .rst(RST),
        .tick(tick_q),
        .start(trig_fire),
        .cw(pat_q == pulser_pkg::PAT_CW),
        .invert(invert_q),
        .cycles(len_eff),
        .busy(busy),
        .drv_a(sh_a),
        .drv_b(sh_b),
        .drv_c(sh_c),
        .drv_d(sh_d)
    );

    ////////////////////////////////////////////////////////////////
    // driver pins and lamps
    logic a_q, b_q, c_q, d_q, oe_q, scope_q, lamp_arm_q, supply_q;
    logic [2:0] lamps_q;
    logic [3:0] drv_vec;

    // a concatenation cannot be indexed directly, so name the vector first
    assign drv_vec = {d_q, c_q, b_q, a_q};

    // variant high parks on enable low; variant low has no enable
    // so its inputs are parked with the clamp held instead
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            {a_q, b_q, c_q, d_q} <= 4'h0;
            oe_q <= 1'b0;
            lamp_arm_q <= 1'b0;
        end else begin
            if (armed_q) begin
                {a_q, b_q, c_q, d_q} <= {sh_a, sh_b, sh_c, sh_d};
            end else begin
                {a_q, b_q} <= 2'h0;
                {c_q, d_q} <= VARIANT_SENSE ? 2'h0 : 2'h3;
            end
            // enable line follows the armed state when variant is high, tied high when variant is low
            oe_q <= VARIANT_SENSE ? armed_q : 1'b1;
            // red lamp mirrors the enable line
            lamp_arm_q <= VARIANT_SENSE ? armed_q : 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scope_q <= 1'b0;
            lamps_q <= 3'h0;
            supply_q <= 1'b0;
        end else begin
            scope_q <= drv_vec[mon_q];
            lamps_q <= {pat_q == pulser_pkg::PAT_CW, pat_q == pulser_pkg::PAT_BURST,
                pat_q == pulser_pkg::PAT_PULSE};
            supply_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // axi-lite read channel, answer one cycle after address
    logic arready_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= pulser_pkg::RESP_OKAY;
        end else if (ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= mapped(ARADDR) ? pulser_pkg::RESP_OKAY : pulser_pkg::RESP_SLVERR;
            unique case (ARADDR)
                pulser_pkg::MODE_OFF: rdata_q <= mode_rd;
                pulser_pkg::BURST_OFF: rdata_q <= {16'h0000, burst_q};
                pulser_pkg::STATUS_OFF: rdata_q <= {trig_count_q, 13'h0000,
                    oe_q, busy, VARIANT_SENSE};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else if (rvalid_q && RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign AWREADY = awready_q;
    assign WREADY = wready_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;
    assign {DRIVE_A, DRIVE_B, DRIVE_C, DRIVE_D} = {a_q, b_q, c_q, d_q};
    assign DRIVE_OE = oe_q;
    assign SCOPE_MONITOR_OUT = scope_q;
    assign {CHOICE_LAMP_3, CHOICE_LAMP_2, CHOICE_LAMP_1} = lamps_q;
    assign ARMED_LAMP = lamp_arm_q;
    assign SUPPLY_GOOD_LAMP = supply_q;

    ////////////////////////////////////////////////////////////////
    // checks
    a_tick_rate: assert property (
        @(posedge CLK) disable iff (RST)
        (rate_q == 3'h0 && tick_q) |-> ##[1:7] (tick_q || rate_q != 3'h0))
        else $error("internal clock tick gap too long at top rate");
    a_int_period: assert property (
        @(posedge CLK) disable iff (RST)
        int_fire |=> trig_cnt_q == '0 && trig_count_q == 16'($past(trig_count_q) + 16'h1))
        else $error("internal trigger did not restart its count");
    a_rate_wrap: assert property (
        @(posedge CLK) disable iff (RST)
        (press[1] && !wr_mode) |=> rate_q == (($past(rate_q) == pulser_pkg::RATE_LAST)
            ? 3'h0 : 3'($past(rate_q) + 3'h1)))
        else $error("rate did not step or wrap");
    a_pattern_step: assert property (
        @(posedge CLK) disable iff (RST)
        (press[0] && !wr_mode) |=> pat_q != $past(pat_q))
        else $error("pattern did not change on press");
    a_monitor_copy: assert property (
        @(posedge CLK) disable iff (RST)
        (mon_q == 2'h1 && $past(mon_q) == 2'h1) |-> scope_q == $past(b_q))
        else $error("scope output is not the selected input");
    a_oe_level: assert property (
        @(posedge CLK) disable iff (RST)
        (VARIANT_SENSE && !armed_q) |=> !oe_q)
        else $error("enable line high while disarmed");
    a_lamp_oe: assert property (
        @(posedge CLK) disable iff (RST)
        lamp_arm_q == oe_q)
        else $error("red lamp disagrees with enable line");
    a_supply_lamp: assert property (
        @(posedge CLK) disable iff (RST)
        1'b1 |=> supply_q)
        else $error("supply lamp dark");
    a_phase_flip: assert property (
        @(posedge CLK) disable iff (RST)
        (press[4] && !wr_mode) |=> invert_q != $past(invert_q))
        else $error("phase did not change on press");
    a_ext_start: assert property (
        @(posedge CLK) disable iff (RST)
        (ext_en_q && EXTERNAL_SYNC_IN && !ext_prev_q && !busy && pat_q != pulser_pkg::PAT_CW)
            |=> busy)
        else $error("external trigger did not start a burst");
    a_disarm_quiet: assert property (
        @(posedge CLK) disable iff (RST)
        !armed_q |=> !a_q && !b_q)
        else $error("drive active while disarmed");
    a_duty_cap: assert property (
        @(posedge CLK) disable iff (RST)
        (pat_q == pulser_pkg::PAT_BURST && rate_q >= pulser_pkg::PW_LIMIT_RATE)
            |-> len_eff <= pulser_pkg::PW_MAX_CYC)
        else $error("slow burst exceeds quarter duty");
    a_press_once: assert property (
        @(posedge CLK) disable iff (RST)
        press[0] |=> !press[0])
        else $error("one press gave two steps");
endmodule
`default_nettype wire

// ===== core/pulser_pkg.sv
// shared constants and types for the pulser pattern controller
package pulser_pkg;
    ////////////////////////////////////////////////////////////////
    // clock and timing
    localparam longint unsigned CLK_HZ = 250_000_000;
    // internal clock at the fastest rate step
    localparam longint unsigned BASE_HZ = 40_000_000;
    localparam logic [31:0] NCO_INC = 32'((BASE_HZ << 32) / CLK_HZ);
    localparam int TRIG_HZ = 5000;
    localparam int TRIG_DIV = int'(BASE_HZ) / TRIG_HZ;
    localparam int DEBOUNCE_MS = 5;
    localparam int DEBOUNCE_CYC = int'(CLK_HZ / 1000) * DEBOUNCE_MS;
    // rate index of 5.0 MHz output and the 25 percent cycle cap
    localparam logic [2:0] PW_LIMIT_RATE = 3'h2;
    localparam logic [15:0] PW_MAX_CYC = 16'(TRIG_DIV / 8);
    localparam logic [2:0] RATE_LAST = 3'h5;
    ////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] MODE_OFF = 8'h00;
    localparam logic [7:0] BURST_OFF = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;
    localparam int MODE_PAT_LSB = 0;
    localparam int MODE_RATE_LSB = 2;
    localparam int MODE_MON_LSB = 5;
    localparam int MODE_ARM_BIT = 7;
    localparam int MODE_INV_BIT = 8;
    localparam int MODE_EXT_BIT = 9;
    localparam logic [2:0] RATE_RST = 3'h0;
    localparam logic [1:0] MON_RST = 2'h0;
    localparam logic [15:0] BURST_RST = 16'h0008;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        PAT_PULSE = 2'b00,
        PAT_BURST = 2'b01,
        PAT_CW = 2'b10
    } pattern_type;
endpackage

// ===== tb/driver_model.sv
// pulser driver input stage: counts drive pulses while enabled
`timescale 1ns/1ps
`default_nettype none
module driver_model (
    // driver inputs
    input wire logic clk,
    input wire logic clear,
    input wire logic in_a,
    input wire logic oe,
    // observation
    output var int a_edges
);
    logic a_q;
    always @(posedge clk) begin
        a_q <= in_a;
        if (clear) begin
            a_edges <= 0;
        end else if (oe && in_a && !a_q) begin
            a_edges <= a_edges + 1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the pulser pattern controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic CLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA, rv;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DRIVE_A, DRIVE_B, DRIVE_C, DRIVE_D;
    logic DRIVE_OE, SCOPE_MONITOR_OUT, CHOICE_LAMP_1, CHOICE_LAMP_2, CHOICE_LAMP_3;
    logic ARMED_LAMP, SUPPLY_GOOD_LAMP, EXTERNAL_SYNC_IN = 0, VARIANT_SENSE = 1, clr = 1;
    logic [1:0] BRESP, RRESP, rr;
    logic [4:0] b = 5'h1F;
    logic [3:0] pd;
    int bad_count = 0, checked = 0, cyc = 0, edges;
    pulser_ctrl #(.DEBOUNCE_CYCLES(4), .TRIG_TICKS(40)) u_dut (.CLK, .RST, .AWADDR, .AWVALID,
        .AWREADY, .WDATA, .WSTRB(4'hF), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
        .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .PATTERN_BUTTON_N(b[0]),
        .RATE_BUTTON_N(b[1]), .MONITOR_BUTTON_N(b[2]), .ENABLE_BUTTON_N(b[3]),
        .PHASE_BUTTON_N(b[4]), .EXTERNAL_SYNC_IN, .VARIANT_SENSE, .DRIVE_A, .DRIVE_B,
        .DRIVE_C, .DRIVE_D, .DRIVE_OE, .SCOPE_MONITOR_OUT, .CHOICE_LAMP_1, .CHOICE_LAMP_2,
        .CHOICE_LAMP_3, .ARMED_LAMP, .SUPPLY_GOOD_LAMP);
    driver_model u_drv (.clk(CLK), .clear(clr), .in_a(DRIVE_A), .oe(DRIVE_OE), .a_edges(edges));
    // bench clock stands in for the board clock
    initial begin
        forever #2 CLK = ~CLK;
    end
    // drive history for the monitor copy, and the hang limit
    always @(posedge CLK) begin
        pd <= {DRIVE_D, DRIVE_C, DRIVE_B, DRIVE_A};
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one bus cycle; releases each channel only once it is taken
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        AWADDR <= a;
        ARADDR <= a;
        WDATA <= d;
        {AWVALID, WVALID, BREADY} <= {3{w}};
        {ARVALID, RREADY} <= {2{!w}};
        do begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 0;
            if (WREADY) WVALID <= 0;
            if (ARREADY) ARVALID <= 0;
        end while (!(w ? BVALID : RVALID));
        {rv, rr} = w ? {32'h0, BRESP} : {RDATA, RRESP};
        {BREADY, RREADY} <= 2'h0;
    endtask
    task automatic press(input int i);
        b[i] <= 0;
        repeat (8) @(posedge CLK);
        b[i] <= 1;
        repeat (8) @(posedge CLK);
    endtask
    task automatic t_reset();
        repeat (2) @(posedge CLK);
        check(SUPPLY_GOOD_LAMP, 1);
        check({CHOICE_LAMP_3, CHOICE_LAMP_2, CHOICE_LAMP_1}, 3'h1);
        bus(0, 8'h40, 32'h0);
        check(rr, pulser_pkg::RESP_SLVERR);
        $display("reset test done");
    endtask
    task automatic t_buttons();
        for (int k = 1; k <= 6; k++) begin
            press(1);
            bus(0, pulser_pkg::MODE_OFF, 32'h0);
            check(rv[4:2], k % 6);
        end
        press(0);
        check({CHOICE_LAMP_3, CHOICE_LAMP_2, CHOICE_LAMP_1}, 3'h2);
        press(3);
        check({ARMED_LAMP, DRIVE_OE}, 2'h3);
        press(4);
        press(2);
        bus(0, pulser_pkg::MODE_OFF, 32'h0);
        check(rv, 32'h1A1);
        $display("button test done");
    endtask
    task automatic t_monitor();
        for (int m = 0; m < 4; m++) begin
            bus(1, pulser_pkg::MODE_OFF, 32'h82 | (m << 5));
            repeat (10) @(posedge CLK);
            check({CHOICE_LAMP_3, CHOICE_LAMP_2, CHOICE_LAMP_1}, 3'h4);
            repeat (30) begin
                @(posedge CLK);
                check(SCOPE_MONITOR_OUT, pd[m]);
            end
        end
        $display("monitor test done");
    endtask
    task automatic t_rate(input logic [2:0] r, input int n);
        bus(1, pulser_pkg::MODE_OFF, 32'h82 | {27'h0, r, 2'h0});
        repeat (20) @(posedge CLK);
        clr <= 1;
        @(posedge CLK);
        clr <= 0;
        repeat (500) @(posedge CLK);
        check(edges >= n - 1 && edges <= n + 1, 1);
        $display("rate test done");
    endtask
    task automatic t_ext();
        logic [15:0] n;
        bus(1, pulser_pkg::BURST_OFF, 32'h2);
        bus(1, pulser_pkg::MODE_OFF, 32'h289);
        do bus(0, pulser_pkg::STATUS_OFF, 32'h0); while (rv[1]);
        n = rv[31:16];
        EXTERNAL_SYNC_IN <= 1;
        repeat (3) @(posedge CLK);
        EXTERNAL_SYNC_IN <= 0;
        bus(0, pulser_pkg::STATUS_OFF, 32'h0);
        check({rv[1], rv[31:16] != n}, 2'h3);
        $display("external trigger test done");
    endtask
    task automatic t_variant();
        bus(1, pulser_pkg::MODE_OFF, 32'h0);
        repeat (4) @(posedge CLK);
        check({DRIVE_OE, DRIVE_D, DRIVE_C, DRIVE_B, DRIVE_A}, 5'h00);
        VARIANT_SENSE <= 0;
        repeat (4) @(posedge CLK);
        check({DRIVE_OE, DRIVE_D, DRIVE_C, DRIVE_B, DRIVE_A}, 5'h1C);
        bus(0, pulser_pkg::STATUS_OFF, 32'h0);
        check({rv[2], rv[0]}, 2'h2);
        $display("variant test done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge CLK);
        RST <= 0;
        t_reset();
        t_buttons();
        t_monitor();
        t_rate(3'h0, 40);
        t_rate(3'h2, 10);
        t_ext();
        t_variant();
        complete_run();
    end
endmodule
`default_nettype wire
